// File: core/scpdc_clk_div.v
// Divider that makes the configuration clock in clock-source mode.
`timescale 1ns/100ps
module scpdc_clk_div (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       rst_n,
  // Control.
  input  wire       run_i,
  input  wire [7:0] half_i,
  // Generated clock and edge pulses.
  output reg        clk_o,
  output reg        rise_o,
  output reg        fall_o
);

  reg [7:0] cnt_q;

  // Half period is half_i plus one core cycles; clock rests low when stopped.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 8'h00;
      clk_o  <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q  <= 8'h00;
      clk_o  <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= clk_o;
    end else if (cnt_q >= half_i) begin
      cnt_q  <= 8'h00;
      clk_o  <= ~clk_o;
      rise_o <= ~clk_o;
      fall_o <= clk_o;
    end else begin
      cnt_q  <= cnt_q + 8'h01;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
  end

endmodule // scpdc_clk_div

// File: core/scpdc_consts.vh
// Constants for the serial configuration port with daisy-chain pass-through.
`ifndef SCPDC_CONSTS_VH
`define SCPDC_CONSTS_VH

// Register offsets.
`define SCPDC_OFS_CTRL    8'h00
`define SCPDC_OFS_CLKDIV  8'h04
`define SCPDC_OFS_STARTUP 8'h08
`define SCPDC_OFS_STATUS  8'h0c
`define SCPDC_OFS_FWDCNT  8'h10

// Control register fields.
`define SCPDC_CTRL_ENABLE   0
`define SCPDC_CTRL_SOURCE   1
`define SCPDC_CTRL_DRIVE    2

// Startup register fields.
`define SCPDC_SU_DONE_LSB   0
`define SCPDC_SU_GOE_LSB    4

// Reset values.
`define SCPDC_RST_CTRL      3'h0
`define SCPDC_RST_CLKDIV    8'h04
`define SCPDC_RST_DONE_PH   3'h3
`define SCPDC_RST_GOE_PH    3'h4

// Stream words.
`define SCPDC_SYNC_WORD     32'h5a3c_c3a5
`define SCPDC_START_CMD     32'h0000_0005
`define SCPDC_CRC_POLY      16'h8005

// Pass-through limit: 32 x (2^27 - 1) bits.
`define SCPDC_FWD_LIMIT     32'hffff_ffe0

// Pass-through latency in configuration clock cycles.
`define SCPDC_DELAY_BITS    80
`define SCPDC_PTR_W         7
`define SCPDC_LAST_PHASE    3'h7

`endif

// File: core/scpdc_sync.v
// Two-flop synchroniser with edge detection on the synchronised level.
`timescale 1ns/100ps
module scpdc_sync (
  // Clock and reset.
  input  wire core_clk,
  input  wire rst_n,
  // Asynchronous input.
  input  wire async_i,
  // Synchronised level and edge pulses.
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // The first stage is read only by the second stage.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges compare the synchronised level with its previous value.
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;

endmodule // scpdc_sync

// File: core/scpdc_top.v
// Serial configuration port with own-stream loader and daisy-chain pass-through.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "scpdc_consts.vh"

module scpdc_top #(
  parameter INIT_CYCLES = 64
) (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_n,
  // Register port.
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Configuration clock pin.
  input  wire        config_clock_i,
  output wire        config_clock_o,
  output reg         config_clock_oe,
  // Serial data in and chain output.
  input  wire        din_i,
  output reg         dout_o,
  // Completion pin, open drain or active drive.
  input  wire        done_i,
  output reg         done_o,
  output reg         done_oe,
  // Global output enable towards the fabric.
  output reg         global_output_enable_o
);

  // ************************************************************
  // Local definitions
  // ************************************************************
  localparam ST_INIT  = 3'h0;
  localparam ST_HUNT  = 3'h1;
  localparam ST_LEN   = 3'h2;
  localparam ST_DATA  = 3'h3;
  localparam ST_CMD   = 3'h4;
  localparam ST_CRC   = 3'h5;
  localparam ST_PASS  = 3'h6;
  localparam ST_ERR   = 3'h7;
  localparam DLY      = `SCPDC_DELAY_BITS;
  localparam [`SCPDC_PTR_W-1:0] DLY_LAST = DLY[`SCPDC_PTR_W-1:0] - 1'b1;

  reg  [2:0]  ctrl_q;
  reg  [7:0]  clkdiv_q;
  reg  [2:0]  done_ph_q;
  reg  [2:0]  goe_ph_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [15:0] init_cnt_q;
  reg         init_done_q;
  reg  [31:0] shift_q;
  reg  [4:0]  bit_cnt_q;
  reg  [31:0] words_q;
  reg  [15:0] crc_q;
  reg         crc_err_q;
  reg  [DLY-1:0] dly_q;
  reg  [`SCPDC_PTR_W-1:0] ptr_q;
  reg  [31:0] fwd_cnt_q;
  reg         fwd_full_q;
  reg  [2:0]  phase_q;
  reg         su_run_q;
  reg         su_end_q;
  reg         released_q;

  wire        enable   = ctrl_q[`SCPDC_CTRL_ENABLE];
  wire        src_mode = ctrl_q[`SCPDC_CTRL_SOURCE];
  wire        drive    = ctrl_q[`SCPDC_CTRL_DRIVE];
  wire        ext_rise;
  wire        ext_fall;
  wire        gen_rise;
  wire        gen_fall;
  wire        din_s;
  wire        done_s;
  wire        cc_rise;
  wire        cc_fall;
  wire [31:0] word_now;
  wire        word_end;
  wire [15:0] crc_next;
  wire [2:0]  done_eff;

  // ************************************************************
  // Pin synchronisers and clock generation
  // ************************************************************

  // Configuration clock pin, used in clock-sink mode.
  scpdc_sync u_sync_clk (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_i  (config_clock_i),
    .level_o  (),
    .rise_o   (ext_rise),
    .fall_o   (ext_fall)
  );

  // Serial data pin.
  scpdc_sync u_sync_din (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_i  (din_i),
    .level_o  (din_s),
    .rise_o   (),
    .fall_o   ()
  );

  // Shared completion line as seen on the pin.
  scpdc_sync u_sync_done (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_i  (done_i),
    .level_o  (done_s),
    .rise_o   (),
    .fall_o   ()
  );

  // Divided clock, held low before initialisation.
  scpdc_clk_div u_clk_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run_i    (src_mode & enable & init_done_q),
    .half_i   (clkdiv_q),
    .clk_o    (config_clock_o),
    .rise_o   (gen_rise),
    .fall_o   (gen_fall)
  );

  // Edge source follows the mode; external edges may run freely.
  assign cc_rise = init_done_q & enable & (src_mode ? gen_rise : ext_rise);
  assign cc_fall = init_done_q & enable & (src_mode ? gen_fall : ext_fall);

  // Clock pin driven only in clock-source mode.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_clock_oe <= 1'b0;
    end else begin
      config_clock_oe <= src_mode & enable;
    end
  end

  // Internal initialisation delay after reset.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_q  <= 16'h0000;
      init_done_q <= 1'b0;
    end else if (init_cnt_q == INIT_CYCLES[15:0]) begin
      init_done_q <= 1'b1;
    end else begin
      init_cnt_q  <= init_cnt_q + 16'h0001;
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************

  // Software writes steer mode, rate, drive option and startup phases.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= `SCPDC_RST_CTRL;
      clkdiv_q  <= `SCPDC_RST_CLKDIV;
      done_ph_q <= `SCPDC_RST_DONE_PH;
      goe_ph_q  <= `SCPDC_RST_GOE_PH;
    end else if (reg_wr) begin
      if (reg_addr == `SCPDC_OFS_CTRL) begin
        ctrl_q <= reg_wdata[2:0];
      end else if (reg_addr == `SCPDC_OFS_CLKDIV) begin
        clkdiv_q <= reg_wdata[7:0];
      end else if (reg_addr == `SCPDC_OFS_STARTUP) begin
        done_ph_q <= reg_wdata[`SCPDC_SU_DONE_LSB+2:`SCPDC_SU_DONE_LSB];
        goe_ph_q  <= reg_wdata[`SCPDC_SU_GOE_LSB+2:`SCPDC_SU_GOE_LSB];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped and idle read as zero.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_addr == `SCPDC_OFS_CTRL) begin
      reg_rdata <= {29'h0, ctrl_q};
    end else if (reg_addr == `SCPDC_OFS_CLKDIV) begin
      reg_rdata <= {24'h0, clkdiv_q};
    end else if (reg_addr == `SCPDC_OFS_STARTUP) begin
      reg_rdata <= {25'h0, goe_ph_q, 1'b0, done_ph_q};
    end else if (reg_addr == `SCPDC_OFS_STATUS) begin
      reg_rdata <= {20'h0, phase_q, fwd_full_q, init_done_q,
                    global_output_enable_o, released_q, crc_err_q, 1'b0, state_q};
    end else if (reg_addr == `SCPDC_OFS_FWDCNT) begin
      reg_rdata <= fwd_cnt_q;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // Own stream loader
  // ************************************************************

  // Incoming bit joins at the bottom, so the first bit ends up highest.
  assign word_now = {shift_q[30:0], din_s};
  assign word_end = (bit_cnt_q == 5'h1f);

  // Serial CRC step over the current bit.
  assign crc_next = {crc_q[14:0], 1'b0} ^
                    ((crc_q[15] ^ din_s) ? `SCPDC_CRC_POLY : 16'h0000);

  // Next state of the loader, advanced on rising clock edges except when leaving ST_INIT.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_INIT: begin
        if (init_done_q) begin
          state_d = ST_HUNT;
        end
      end
      ST_HUNT: begin
        if (word_now == `SCPDC_SYNC_WORD) begin
          state_d = ST_LEN;
        end
      end
      ST_LEN: begin
        if (word_end) begin
          state_d = (word_now == 32'h0000_0000) ? ST_CMD : ST_DATA;
        end
      end
      ST_DATA: begin
        if (word_end && words_q == 32'h0000_0001) begin
          state_d = ST_CMD;
        end
      end
      ST_CMD: begin
        if (word_end) begin
          state_d = (word_now == `SCPDC_START_CMD) ? ST_CRC : ST_ERR;
        end
      end
      ST_CRC: begin
        if (word_end) begin
          state_d = (word_now[15:0] == crc_q) ? ST_PASS : ST_ERR;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
  end

  // One bit taken on each rising configuration clock edge.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_INIT;
      shift_q   <= 32'h0000_0000;
      bit_cnt_q <= 5'h00;
      words_q   <= 32'h0000_0000;
      crc_q     <= 16'h0000;
      crc_err_q <= 1'b0;
    end else if (state_q == ST_INIT) begin
      state_q <= state_d;
    end else if (cc_rise) begin
      state_q <= state_d;
      shift_q <= word_now;
      // Word framing restarts right after the sync word.
      if (state_q == ST_HUNT) begin
        bit_cnt_q <= 5'h00;
      end else begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (state_q == ST_LEN && word_end) begin
        words_q <= word_now;
        crc_q   <= 16'h0000;
      end
      // Only own data words feed the CRC.
      if (state_q == ST_DATA) begin
        crc_q <= crc_next;
        if (word_end) begin
          words_q <= words_q - 32'h0000_0001;
        end
      end
      if (state_d == ST_ERR && state_q != ST_ERR) begin
        crc_err_q <= (state_q == ST_CRC);
      end
    end
  end

  // ************************************************************
  // Daisy-chain pass-through
  // ************************************************************

  // Later bits, sync word included, go into the delay line.
  // Zeros are written and counting stops once the pass-through limit is reached.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_q      <= {DLY{1'b0}};
      ptr_q      <= {`SCPDC_PTR_W{1'b0}};
      fwd_cnt_q  <= 32'h0000_0000;
      fwd_full_q <= 1'b0;
    end else if (cc_rise && state_q == ST_PASS) begin
      dly_q[ptr_q] <= din_s & ~fwd_full_q;
      ptr_q <= (ptr_q == DLY_LAST) ? {`SCPDC_PTR_W{1'b0}} : ptr_q + 1'b1;
      if (!fwd_full_q) begin
        fwd_cnt_q  <= fwd_cnt_q + 32'h0000_0001;
        fwd_full_q <= (fwd_cnt_q == `SCPDC_FWD_LIMIT - 32'h0000_0001);
      end
    end
  end

  // Oldest slot driven out on the falling edge.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_o <= 1'b0;
    end else if (cc_fall && state_q == ST_PASS) begin
      dout_o <= dly_q[ptr_q];
    end
  end

  // ************************************************************
  // Startup sequence and completion pin
  // ************************************************************

  // Release phase is clamped so it never follows the enable phase.
  assign done_eff = (done_ph_q > goe_ph_q) ? goe_ph_q : done_ph_q;

  // Phases step per rising edge; enable waits for the line.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q                <= 3'h0;
      su_run_q               <= 1'b0;
      su_end_q               <= 1'b0;
      released_q             <= 1'b0;
      global_output_enable_o <= 1'b0;
    end else if (cc_rise) begin
      if (!su_run_q && !su_end_q && state_q == ST_CRC && state_d == ST_PASS) begin
        su_run_q <= 1'b1;
      end else if (su_run_q) begin
        if (phase_q >= done_eff) begin
          released_q <= 1'b1;
        end
        if (phase_q >= goe_ph_q && released_q && done_s) begin
          global_output_enable_o <= 1'b1;
        end
        if (phase_q == goe_ph_q && !(released_q && done_s)) begin
          phase_q <= phase_q;
        end else if (phase_q == `SCPDC_LAST_PHASE) begin
          su_run_q <= 1'b0;
          su_end_q <= 1'b1;
        end else begin
          phase_q <= phase_q + 3'h1;
        end
      end
    end
  end

  // Low until released, then high only with active drive, else floated.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_o  <= 1'b0;
      done_oe <= 1'b1;
    end else if (!released_q) begin
      done_o  <= 1'b0;
      done_oe <= 1'b1;
    end else begin
      done_o  <= drive;
      done_oe <= drive;
    end
  end

endmodule // scpdc_top

// File: verification/scpdc_src_model.sv
// Behavioural serial data source feeding the configuration port.
`timescale 1ns/100ps
module scpdc_src_model (
  // Mode and resolved clock pin.
  input wire sink_mode,
  input wire cfg_pin,
  // Driven lines.
  output reg ext_clk,
  output reg din
);
  // ****************************************
  // Stream store
  // ****************************************
  reg     bits [0:1023];
  reg     armed;
  integer nbits;
  integer idx;

  // Starts a stream with its first bit already on the line.
  task start(input integer n);
    begin
      nbits = n;
      idx = 0;
      armed = 1'b1;
      din = bits[0];
    end
  endtask

  always @(posedge cfg_pin) begin
    if (idx < nbits) begin
      idx <= idx + 1;
    end
  end

  // Data moves after a falling edge; past the stream the line keeps toggling.
  always @(negedge cfg_pin) begin
    din <= (idx < nbits) ? bits[idx] : ~din;
  end

  // gated clock
  // In sink mode the clock runs at 800 ns until armed and through the frame, then rests low.
  initial begin
    ext_clk = 1'b0;
    din = 1'b0;
    armed = 1'b0;
    nbits = 0;
    idx = 0;
    forever begin
      #400;
      ext_clk = (sink_mode && (idx < nbits || !armed)) ? ~ext_clk : 1'b0;
    end
  end
endmodule // scpdc_src_model

// File: verification/scpdc_top_sva.sv
// Assertion checker for the serial configuration port.
`timescale 1ns/100ps
module scpdc_top_sva #(
  parameter INIT_CYCLES = 64
) (
  // Clock and reset.
  input wire        core_clk,
  input wire        rst_n,
  // Register writes.
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  // Pins.
  input wire        config_clock_i,
  input wire        config_clock_o,
  input wire        config_clock_oe,
  input wire        dout_o,
  input wire        done_i,
  input wire        done_o,
  input wire        done_oe,
  input wire        global_output_enable_o
);
  // ****************************************
  // Helper state
  // ****************************************
  reg  [7:0] icnt_q;
  reg  [7:0] div_q;
  reg  [8:0] hcnt_q;
  reg  [3:0] fcnt_q;
  reg        co_q;
  reg        pin_q;
  reg        tog_q;
  reg        drv_q;
  reg        oe_q;
  wire       pin_w = config_clock_oe ? config_clock_o : config_clock_i;
  wire       tgl_w = co_q != config_clock_o;

  // Tracks software settings and the timing of clock pin edges.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      icnt_q <= 8'h00;
      div_q  <= 8'h04;
      hcnt_q <= 9'h000;
      fcnt_q <= 4'hf;
      co_q   <= 1'b0;
      pin_q  <= 1'b0;
      tog_q  <= 1'b0;
      drv_q  <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      icnt_q <= (icnt_q == 8'hff) ? icnt_q : icnt_q + 8'h01;
      if (reg_wr && reg_addr == 8'h04) begin
        div_q <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == 8'h00) begin
        drv_q <= reg_wdata[2];
        oe_q  <= reg_wdata[0] & reg_wdata[1];
      end
      hcnt_q <= tgl_w ? 9'h000 : ((hcnt_q == 9'h1ff) ? hcnt_q : hcnt_q + 9'h001);
      fcnt_q <= (pin_q && !pin_w) ? 4'h0 : ((fcnt_q == 4'hf) ? fcnt_q : fcnt_q + 4'h1);
      co_q   <= config_clock_o;
      pin_q  <= pin_w;
      tog_q  <= tog_q | (tgl_w & config_clock_oe);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_clk_quiet: assert property (!config_clock_oe |-> !config_clock_o)
    else $error("clock output active while pin not driven");
  a_init_quiet: assert property (icnt_q < INIT_CYCLES |-> !config_clock_o)
    else $error("clock moved during initialisation");
  a_oe_ctrl: assert property (reg_wr && reg_addr == 8'h00 |=> ##1 config_clock_oe == oe_q)
    else $error("clock pin drive does not follow control");
  a_half_period: assert property (config_clock_oe && tog_q && tgl_w |-> hcnt_q == {1'b0, div_q})
    else $error("clock half period differs from divider");
  a_dout_fall: assert property ($changed(dout_o) |-> fcnt_q < 4'h6)
    else $error("chain output changed away from a falling edge");
  a_goe_release: assert property (global_output_enable_o |-> !done_oe || done_o)
    else $error("output enable while completion line held low");
  a_goe_line: assert property ($rose(global_output_enable_o) |-> $past(done_i))
    else $error("output enable before completion line high");
  a_drive_only: assert property (!drv_q |-> !done_o)
    else $error("completion pin driven high without active drive");

  c_goe: cover property ($rose(global_output_enable_o));
  c_fwd: cover property ($rose(dout_o));
  c_drive: cover property (done_oe && done_o);
endmodule // scpdc_top_sva

bind scpdc_top scpdc_top_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .config_clock_i(config_clock_i), .config_clock_o(config_clock_o),
  .config_clock_oe(config_clock_oe), .dout_o(dout_o), .done_i(done_i), .done_o(done_o),
  .done_oe(done_oe), .global_output_enable_o(global_output_enable_o)
);

// File: verification/scpdc_top_tb.sv
// Self-checking testbench for the serial configuration port.
`timescale 1ns/100ps
`include "scpdc_consts.vh"
module scpdc_top_tb;
  // ****************************************
  // Signals
  // ****************************************
  reg         core_clk;
  reg         rst_n;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg         sink;
  reg         mon_on;
  reg         fwd_on;
  wire [31:0] reg_rdata;
  wire        clk_o, clk_oe, ext_clk, din, dout, done_o, done_oe, goe;
  integer     err_count, n_checks, own_len, nb, j;
  // Resolved clock pin and pulled-up completion line.
  wire        pin = clk_oe ? clk_o : ext_clk;
  wire        done_w = !(done_oe && !done_o);

  scpdc_top #(.INIT_CYCLES(4)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_clock_i(pin),
    .config_clock_o(clk_o), .config_clock_oe(clk_oe), .din_i(din), .dout_o(dout),
    .done_i(done_w), .done_o(done_o), .done_oe(done_oe), .global_output_enable_o(goe)
  );
  scpdc_src_model model (.sink_mode(sink), .cfg_pin(pin), .ext_clk(ext_clk), .din(din));

  // Makes the 10 MHz core clock.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task chk(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask

  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask

  // Reads a register and compares the masked value in the answer cycle.
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata & m, e);
    end
  endtask

  task push(input [31:0] w);
    integer k;
    begin
      for (k = 31; k >= 0; k = k - 1) begin
        model.bits[nb] = w[k];
        nb = nb + 1;
      end
    end
  endtask

  function [15:0] crc16(input [63:0] w);
    reg [15:0] c;
    integer    k;
    begin
      c = 16'h0000;
      for (k = 63; k >= 0; k = k - 1) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k]) ? 16'h8005 : 16'h0000);
      end
      crc16 = c;
    end
  endfunction

  // Resets, loads one own stream plus a downstream stream, then checks the outcome.
  task run(input [2:0] ctrl, input [31:0] su, input bad);
    integer k;
    begin
      sink = !ctrl[1];
      model.armed = 1'b0;
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      rdc(`SCPDC_OFS_CTRL, 32'hffffffff, 32'h00000000);
      rdc(`SCPDC_OFS_CLKDIV, 32'hffffffff, 32'h00000004);
      rdc(`SCPDC_OFS_STARTUP, 32'hffffffff, 32'h00000043);
      wr(`SCPDC_OFS_STATUS, 32'hffffffff);
      rdc(`SCPDC_OFS_STATUS, 32'h0000017f, 32'h00000001);
      wr(8'h14, 32'hffffffff);
      rdc(8'h14, 32'hffffffff, 32'h00000000);
      nb = 0;
      push(`SCPDC_SYNC_WORD);
      push(32'h00000002);
      push(32'h1234abcd);
      push(32'h80000001);
      push(`SCPDC_START_CMD);
      push({16'h0000, crc16({32'h1234abcd, 32'h80000001}) ^ {15'h0000, bad}});
      own_len = nb;
      push(`SCPDC_SYNC_WORD);
      for (k = 1; k < 8; k = k + 1) begin
        push(32'hc0de0000 | k);
      end
      wr(`SCPDC_OFS_CLKDIV, 32'h00000009);
      wr(`SCPDC_OFS_STARTUP, su);
      fwd_on = !bad;
      if (!sink) begin
        model.start(nb);
      end
      wr(`SCPDC_OFS_CTRL, {29'h0, ctrl});
      if (sink) begin
        model.start(nb);
      end
      mon_on = 1'b1;
      for (k = 0; k < 40000 && model.idx < nb; k = k + 1) begin
        @(posedge core_clk);
      end
      mon_on = 1'b0;
      if (k == 40000) begin
        err_count = err_count + 1;
        conclude;
      end
      repeat (40) @(posedge core_clk);
      rdc(`SCPDC_OFS_STATUS, 32'h000000f7, bad ? 32'h00000097 : 32'h000000e6);
      chk(goe, !bad);
      chk({done_oe, done_o}, bad ? 2'b10 : {ctrl[2], ctrl[2]});
      chk(clk_oe, ctrl[1] & ctrl[0]);
      if (sink || bad) begin
        rdc(`SCPDC_OFS_FWDCNT, 32'hffffffff, bad ? 32'h0 : 32'h00000100);
      end
    end
  endtask

  // no own bits
  // Compares the chain output at each falling pin edge with the delayed input.
  always @(negedge pin) begin
    if (mon_on) begin
      j = model.idx - 81;
      chk(dout, (fwd_on && j >= own_len) ? model.bits[j] : 1'b0);
    end
  end

  // Runs source mode, sink mode with active drive, then a corrupted check word.
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sink = 1'b0;
    mon_on = 1'b0;
    fwd_on = 1'b0;
    err_count = 0;
    n_checks = 0;
    own_len = 0;
    nb = 0;
    run(3'h3, 32'h00000043, 1'b0);
    run(3'h5, 32'h00000046, 1'b0);
    run(3'h3, 32'h00000043, 1'b1);
    conclude;
  end
endmodule // scpdc_top_tb
